// [rtl/periodic_timer.sv]
`timescale 1ns/1ps
`include "periodic_timer_cfg.svh"

module periodic_timer
  import periodic_timer_pkg::*;
#(
  parameter int INSTANCE = 0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extClockPin,
  input wire logic captureInputPin,
  output logic timerOut,
  output logic timerIrq
);
  // ----------------------------------------------------------
  // Width per instance
  // ----------------------------------------------------------
  localparam int CW = (INSTANCE < 2) ? `PT_WIDTH_SMALL : `PT_WIDTH_LARGE; // RULE20
  localparam logic [`PT_MAX_WIDTH-1:0] CMASK =
    (`PT_MAX_WIDTH)'((32'h0001_0000 >> (`PT_MAX_WIDTH - CW)) - 1);

  function automatic logic [`PT_MAX_WIDTH-1:0] trim(input logic [31:0] v);
    trim = v[`PT_MAX_WIDTH-1:0] & CMASK;
  endfunction

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  logic counterRun_q;
  logic [1:0] timerModeSel_q;
  logic [1:0] pinActionSel_q;
  logic outputInitialLevel_q;
  logic outputInvert_q;
  logic captureSourceSel_q;
  logic clearSourceSel_q;
  logic extEdgeFall_q;
  logic [`PT_MAX_WIDTH-1:0] compareAValue_q;
  logic [`PT_MAX_WIDTH-1:0] compareAValue_d;
  logic [`PT_MAX_WIDTH-1:0] comparePValue_q;
  logic [`PT_MAX_WIDTH-1:0] count_q;
  logic [`PT_MAX_WIDTH-1:0] count_d;
  logic runLast_q;
  logic pulseLevel_q;
  logic compareAFlag_q;
  logic comparePFlag_q;
  logic capturePend_q;
  logic timerOut_q;
  logic [31:0] prdata_q;
  run_state_t state_q;
  run_state_t state_d;

  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  logic extLevel;
  logic extRise;
  logic extFall;
  logic capLevel;
  logic capRise;
  logic capFall;

  pin_sync_edge extSync (
    .clock(clock),
    .rst(rst),
    .pinIn(extClockPin),
    .level(extLevel),
    .rise(extRise),
    .fall(extFall)
  ); // RULE24

  pin_sync_edge capSync (
    .clock(clock),
    .rst(rst),
    .pinIn(captureInputPin),
    .level(capLevel),
    .rise(capRise),
    .fall(capFall)
  ); // RULE24 RULE16

  // ----------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------
  wire busAccess = psel & penable;
  wire busWrite = busAccess & pwrite;
  wire busRead = busAccess & ~pwrite;
  wire hitCtrl = (paddr == `PT_ADDR_CTRL);
  wire hitCmpA = (paddr == `PT_ADDR_CMPA);
  wire hitCmpP = (paddr == `PT_ADDR_CMPP);
  wire hitCnt = (paddr == `PT_ADDR_CNT);
  wire hitStat = (paddr == `PT_ADDR_STAT);
  wire hitAny = hitCtrl | hitCmpA | hitCmpP | hitCnt | hitStat;
  wire wrCtrl = busWrite & hitCtrl;
  wire wrCmpA = busWrite & hitCmpA;
  wire wrCmpP = busWrite & hitCmpP;
  wire wrStat = busWrite & hitStat;

  assign pready = 1'b1;
  assign pslverr = busAccess & ~hitAny;

  // ----------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------
  wire modePulse = (timerModeSel_q == MODE_PULSE) && (pinActionSel_q == `PT_IO_NONE); // RULE1
  wire modeCapture = (timerModeSel_q == MODE_CAPTURE); // RULE8
  wire modeCompare = (timerModeSel_q == MODE_COMPARE) || (timerModeSel_q == MODE_TIMER);
  wire modePwm = (timerModeSel_q == MODE_PULSE) && !modePulse;

  wire runRise = counterRun_q & ~runLast_q;
  wire matchA = counterRun_q && (count_q == compareAValue_q); // RULE23
  wire matchP = counterRun_q && (count_q == comparePValue_q); // RULE23
  wire atMax = (count_q == CMASK);

  // Trigger edge on the external pin, its polarity held in a control bit
  wire extTrig = extEdgeFall_q ? extFall : extRise;
  wire pulseTrigger = modePulse && extTrig && !counterRun_q; // RULE3
  wire pulseStop = modePulse && matchA && !runRise; // RULE5

  // Capture source and edge select
  wire srcRise = captureSourceSel_q ? extRise : capRise; // RULE9
  wire srcFall = captureSourceSel_q ? extFall : capFall; // RULE9
  logic edgeHit;
  always_comb begin
    case (capture_edge_t'(pinActionSel_q))
      EDGE_RISE: edgeHit = srcRise;
      EDGE_FALL: edgeHit = srcFall;
      EDGE_BOTH: edgeHit = srcRise | srcFall;
      default: edgeHit = 1'b0; // RULE10
    endcase
  end
  // Edge seen two clocks after the pin; latched one clock later
  wire captureHit = modeCapture && counterRun_q && edgeHit; // RULE12 RULE18

  // ----------------------------------------------------------
  // Counter next value
  // ----------------------------------------------------------
  wire pWrap = (comparePValue_q == '0) ? atMax : matchP; // RULE14
  always_comb begin
    count_d = count_q;
    if (runRise) begin
      count_d = '0; // RULE6
    end else if (counterRun_q) begin
      if (modePulse) begin
        count_d = trim(32'(count_q) + 32'h0000_0001); // RULE7
      end else if (modeCapture && pWrap) begin
        count_d = '0; // RULE13
      end else if (modeCompare && clearSourceSel_q && matchA) begin
        count_d = '0;
      end else if (!modeCapture && !clearSourceSel_q && pWrap) begin
        count_d = '0;
      end else begin
        count_d = trim(32'(count_q) + 32'h0000_0001); // RULE11
      end
    end
  end

  // ----------------------------------------------------------
  // Run state
  // ----------------------------------------------------------
  always_comb begin
    case (state_q)
      ST_IDLE: state_d = counterRun_q ? ST_RUN : ST_IDLE;
      ST_RUN: state_d = counterRun_q ? ST_RUN : ST_STOP;
      ST_STOP: state_d = counterRun_q ? ST_RUN : ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // Captured counter lands in compare A, else software value
  always_comb begin
    compareAValue_d = compareAValue_q;
    if (wrCmpA) begin
      compareAValue_d = trim(pwdata);
    end
    if (captureHit) begin
      compareAValue_d = count_q; // RULE12
    end
  end

  // ----------------------------------------------------------
  // Control register
  // ----------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      counterRun_q <= 1'b0;
      timerModeSel_q <= 2'h0;
      pinActionSel_q <= 2'h0;
      outputInitialLevel_q <= 1'b0;
      outputInvert_q <= 1'b0;
      captureSourceSel_q <= 1'b0;
      clearSourceSel_q <= 1'b0;
      extEdgeFall_q <= 1'b0;
    end else begin
      if (wrCtrl) begin
        timerModeSel_q <= pwdata[`PT_CTRL_MODE_HI:`PT_CTRL_MODE_LO];
        pinActionSel_q <= pwdata[`PT_CTRL_IO_HI:`PT_CTRL_IO_LO];
        outputInitialLevel_q <= pwdata[`PT_CTRL_OC];
        outputInvert_q <= pwdata[`PT_CTRL_POL];
        captureSourceSel_q <= pwdata[`PT_CTRL_CAPTS];
        clearSourceSel_q <= pwdata[`PT_CTRL_CCLR];
        extEdgeFall_q <= pwdata[`PT_CTRL_EXT_EDGE];
      end
      // Hardware clear wins, then hardware set, then software
      if (pulseStop) begin
        counterRun_q <= 1'b0; // RULE5 RULE4
      end else if (pulseTrigger) begin
        counterRun_q <= 1'b1; // RULE3
      end else if (wrCtrl) begin
        counterRun_q <= pwdata[`PT_CTRL_RUN];
      end
    end
  end

  // ----------------------------------------------------------
  // Counter, compare values and output
  // ----------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      count_q <= '0;
      compareAValue_q <= '0;
      comparePValue_q <= '0;
      runLast_q <= 1'b0;
      pulseLevel_q <= 1'b0;
      state_q <= ST_IDLE;
    end else begin
      count_q <= count_d;
      compareAValue_q <= compareAValue_d;
      runLast_q <= counterRun_q;
      state_q <= state_d;
      if (wrCmpP) begin
        comparePValue_q <= trim(pwdata);
      end
      if (runRise) begin
        pulseLevel_q <= outputInitialLevel_q; // RULE21 RULE2
      end else if (modePulse && !counterRun_q) begin
        pulseLevel_q <= ~outputInitialLevel_q; // RULE4
      end else if (modeCompare && matchA) begin
        pulseLevel_q <= ~pulseLevel_q;
      end
    end
  end

  // Capture holds the pin low; other modes drive it with polarity
  always_ff @(posedge clock) begin
    if (rst) begin
      timerOut_q <= 1'b0;
    end else if (!modeCapture) begin
      timerOut_q <= pulseLevel_q ^ outputInvert_q; // RULE22
    end else begin
      timerOut_q <= 1'b0; // RULE19
    end
  end
  assign timerOut = timerOut_q;

  // ----------------------------------------------------------
  // Flags, set wins over write-one-to-clear
  // ----------------------------------------------------------
  wire setA = pulseStop || capturePend_q || (modeCompare && matchA) || (modePwm && matchA); // RULE5
  wire setP = (modeCapture && counterRun_q && pWrap) || (!modeCapture && !modePulse && matchP); // RULE13

  always_ff @(posedge clock) begin
    if (rst) begin
      compareAFlag_q <= 1'b0;
      comparePFlag_q <= 1'b0;
      capturePend_q <= 1'b0;
    end else begin
      capturePend_q <= captureHit; // RULE17
      if (setA) begin
        compareAFlag_q <= 1'b1;
      end else if (wrStat && pwdata[`PT_STAT_AF]) begin
        compareAFlag_q <= 1'b0;
      end
      if (setP) begin
        comparePFlag_q <= 1'b1;
      end else if (wrStat && pwdata[`PT_STAT_PF]) begin
        comparePFlag_q <= 1'b0;
      end
    end
  end
  assign timerIrq = compareAFlag_q | comparePFlag_q;

  // ----------------------------------------------------------
  // Read data
  // ----------------------------------------------------------
  logic [31:0] readMux;
  always_comb begin
    readMux = `PT_ZERO_WORD;
    if (hitCtrl) begin
      readMux[`PT_CTRL_RUN] = counterRun_q;
      readMux[`PT_CTRL_MODE_HI:`PT_CTRL_MODE_LO] = timerModeSel_q;
      readMux[`PT_CTRL_IO_HI:`PT_CTRL_IO_LO] = pinActionSel_q;
      readMux[`PT_CTRL_OC] = outputInitialLevel_q;
      readMux[`PT_CTRL_POL] = outputInvert_q;
      readMux[`PT_CTRL_CAPTS] = captureSourceSel_q;
      readMux[`PT_CTRL_CCLR] = clearSourceSel_q;
      readMux[`PT_CTRL_EXT_EDGE] = extEdgeFall_q;
    end else if (hitCmpA) begin
      readMux[`PT_MAX_WIDTH-1:0] = compareAValue_q;
    end else if (hitCmpP) begin
      readMux[`PT_MAX_WIDTH-1:0] = comparePValue_q;
    end else if (hitCnt) begin
      readMux[`PT_MAX_WIDTH-1:0] = count_q;
    end else if (hitStat) begin
      readMux[`PT_STAT_AF] = compareAFlag_q;
      readMux[`PT_STAT_PF] = comparePFlag_q;
    end
  end

  // Read data registered at setup so it is stable in the access phase
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata_q <= `PT_ZERO_WORD;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= readMux;
    end
  end
  assign prdata = prdata_q;

  wire unusedLevels = extLevel ^ capLevel ^ busRead;
endmodule // periodic_timer

// [rtl/periodic_timer_cfg.svh]
// Contract
// [RULE1] Software selects mode 10, pin action 11
// [RULE2] Run bit rise starts counter, pulse leads
// [RULE3] External clock pin edge sets run bit
// [RULE4] Run bit falling ends the pulse
// [RULE5] Compare A match clears run, interrupts
// [RULE6] Counter zeroed only on run rise
// [RULE7] Compare P and clear select ignored
// [RULE8] Software selects mode 01 for capture
// [RULE9] Capture source select picks input pin
// [RULE10] Pin action picks edge; 11 disables capture
// [RULE11] Counter free-runs until run bit falls
// [RULE12] Active edge copies counter, raises interrupt
// [RULE13] Compare P match zeroes counter, interrupts
// [RULE14] Compare P zero gives full count
// [RULE15] Software avoids external pin as clock
// [RULE16] Pulses under two clocks may be lost
// [RULE17] Compare A flag follows latch closely
// [RULE18] Edge to latch under 1.5 clocks; code latches two to three clocks after the pin edge
// [RULE19] Capture ignores clear, level, invert bits
// [RULE20] Instances 0-1 are 10-bit, 2-3 16-bit
// [RULE21] Run rise loads output initial level
// [RULE22] Invert bit reverses output polarity
// [RULE23] Matches are equality with compare values
// [RULE24] Capture pins synchronised before edge detect
`ifndef PERIODIC_TIMER_CFG_SVH
`define PERIODIC_TIMER_CFG_SVH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define PT_ADDR_CTRL 12'h000
`define PT_ADDR_CMPA 12'h004
`define PT_ADDR_CMPP 12'h008
`define PT_ADDR_CNT 12'h00C
`define PT_ADDR_STAT 12'h010

// ------------------------------------------------------------
// Control and status field positions
// ------------------------------------------------------------
`define PT_CTRL_RUN 0
`define PT_CTRL_MODE_LO 1
`define PT_CTRL_MODE_HI 2
`define PT_CTRL_IO_LO 3
`define PT_CTRL_IO_HI 4
`define PT_CTRL_OC 5
`define PT_CTRL_POL 6
`define PT_CTRL_CAPTS 7
`define PT_CTRL_CCLR 8
`define PT_CTRL_EXT_EDGE 9
`define PT_STAT_AF 0
`define PT_STAT_PF 1

// ------------------------------------------------------------
// Widths and constants
// ------------------------------------------------------------
`define PT_WIDTH_SMALL 10
`define PT_WIDTH_LARGE 16
`define PT_MAX_WIDTH 16
`define PT_ZERO_WORD 32'h0000_0000
`define PT_IO_NONE 2'h3
`define PT_SYNC_STAGES 2

`endif

// [rtl/periodic_timer_pkg.sv]
package periodic_timer_pkg;
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'h0,
    MODE_CAPTURE = 2'h1,
    MODE_PULSE = 2'h2,
    MODE_TIMER = 2'h3
  } timer_mode_t;

  typedef enum logic [1:0] {
    EDGE_RISE = 2'h0,
    EDGE_FALL = 2'h1,
    EDGE_BOTH = 2'h2,
    EDGE_NONE = 2'h3
  } capture_edge_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_STOP = 3'b100
  } run_state_t;
endpackage

// [rtl/pin_sync_edge.sv]
`timescale 1ns/1ps
`include "periodic_timer_cfg.svh"

module pin_sync_edge (
  input wire logic clock,
  input wire logic rst,
  input wire logic pinIn,
  output logic level,
  output logic rise,
  output logic fall
);
  // ----------------------------------------------------------
  // Two-stage synchroniser, first stage feeds only the second
  // ----------------------------------------------------------
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pinIn;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;
endmodule // pin_sync_edge

// [tb/periodic_timer_assertions.sv]
`timescale 1ns/1ps
`include "periodic_timer_cfg.svh"
module periodic_timer_assertions
  import periodic_timer_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic extClockPin,
  input wire logic captureInputPin,
  input wire logic timerOut,
  input wire logic timerIrq
);
  logic [1:0] modeQ;
  logic [1:0] edgeQ;
  logic ocQ;
  logic polQ;
  logic srcQ;
  logic fallQ;
  wire acc = psel && penable;
  wire ctrlWr = acc && pwrite && paddr == `PT_ADDR_CTRL;
  wire capPin = srcQ ? extClockPin : captureInputPin;

  // ----
  // Shadow of the control fields
  // ----
  always_ff @(posedge clock) begin
    if (rst) begin
      {fallQ, srcQ, polQ, ocQ, edgeQ, modeQ} <= 8'h00;
    end else if (ctrlWr) begin
      {fallQ, srcQ, polQ, ocQ, edgeQ, modeQ} <= {pwdata[9], pwdata[7:1]};
    end
  end

  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);

  // ----
  // Properties
  // ----
  ready_now_a: assert property (acc |-> pready)
    else $error("pready low in access phase");
  unmapped_err_a: assert property (acc && !pwrite && paddr > `PT_ADDR_STAT
      |-> pslverr && prdata == `PT_ZERO_WORD)
    else $error("unmapped read not refused");
  reset_quiet_a: assert property ($fell(rst) |-> !timerOut && !timerIrq)
    else $error("outputs active after reset");
  pulse_lead_a: assert property (
      ctrlWr && pwdata[4:0] == 5'h1d |-> ##[1:3] timerOut == (ocQ ^ polQ))
    else $error("pulse leading level wrong");
  pulse_trail_a: assert property (
      $rose(timerIrq) && modeQ == MODE_PULSE && edgeQ == 2'h3
      |-> ##[0:2] timerOut == !(ocQ ^ polQ))
    else $error("pulse not ended at match");
  ext_trigger_a: assert property (
      modeQ == MODE_PULSE && edgeQ == 2'h3 && !fallQ && $rose(extClockPin)
      |-> ##[2:8] timerOut == (ocQ ^ polQ))
    else $error("pin edge did not start pulse");
  capture_quiet_a: assert property ((modeQ == MODE_CAPTURE)[*3] |-> !timerOut)
    else $error("output driven in capture");
  capture_irq_a: assert property (
      modeQ == MODE_CAPTURE && (edgeQ == 2'h0 && $rose(capPin)
      || edgeQ == 2'h1 && $fell(capPin) || edgeQ == 2'h2 && $changed(capPin))
      |-> ##[1:8] timerIrq)
    else $error("capture edge gave no interrupt");
endmodule // periodic_timer_assertions

// [tb/pin_source.sv]
`timescale 1ns/1ps
module pin_source (
  input wire logic clock,
  output logic extClockPin,
  output logic captureInputPin
);
  // ----
  // Pins rest low between pulses
  // ----
  initial begin
    extClockPin = 1'b0;
    captureInputPin = 1'b0;
  end

  // Width kept at two clocks or more, short ones may be dropped
  task automatic pulse(input logic onExt, input int width);
    @(posedge clock);
    if (onExt) begin
      extClockPin <= 1'b1;
    end else begin
      captureInputPin <= 1'b1;
    end
    repeat (width) @(posedge clock);
    extClockPin <= 1'b0;
    captureInputPin <= 1'b0;
  endtask
endmodule // pin_source

// [tb/testbench.sv]
`timescale 1ns/1ps
`include "periodic_timer_cfg.svh"
module testbench;
  typedef struct {logic [31:0] data; logic [31:0] mask; logic err;} note_t;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic extClockPin;
  logic captureInputPin;
  logic timerOut;
  logic timerIrq;
  logic [31:0] ctrl;
  integer seed = 32'hdf18;
  int nFail = 0;
  int testsRun = 0;
  note_t notes[$];
  note_t nt;

  always #2 clock = ~clock;

  periodic_timer #(.INSTANCE(0)) uut (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .extClockPin(extClockPin),
    .captureInputPin(captureInputPin), .timerOut(timerOut), .timerIrq(timerIrq));
  pin_source pins (.clock(clock), .extClockPin(extClockPin),
    .captureInputPin(captureInputPin));

  // ----
  // Bus tasks
  // ----
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Note queued before the setup so the watcher never races it
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back('{e, m, a > `PT_ADDR_STAT});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Called at a falling edge, away from the edge that launches the pin
  task automatic pin_check(input logic got, input logic exp);
    testsRun++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value at %0t: pin %b, expected %b", $time, got, exp);
    end
  endtask

  always @(posedge clock) begin
    if (psel && penable && pready && !pwrite && notes.size() > 0) begin
      nt = notes.pop_front();
      testsRun++;
      if (((prdata ^ nt.data) & nt.mask) !== 32'h0000_0000 || pslverr !== nt.err) begin
        nFail++;
        $display("wrong value at %0t: addr %h read %h", $time, paddr, prdata);
      end
    end
  end

  task automatic final_report();
    $display("checks %0d, mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----
  // Scenarios
  // ----
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(12'(4 * i), 32'h0000_0000, ALL);
    end
    wr(`PT_ADDR_CNT, 32'h0000_0155);
    rd(`PT_ADDR_CNT, 32'h0000_0000, ALL);
    ctrl = $random(seed);
    wr(`PT_ADDR_CMPA, ctrl);
    rd(`PT_ADDR_CMPA, ctrl & 32'h0000_03ff, ALL);
    for (int k = 0; k < 4; k++) begin
      // Short compare P and clear select must not cut the pulse
      wr(`PT_ADDR_CMPA, 32'h0000_0014);
      wr(`PT_ADDR_CMPP, 32'h0000_0005);
      ctrl = 32'h0000_001c | (k << 5) | ((k & 1) << 8);
      wr(`PT_ADDR_CTRL, ctrl);
      wr(`PT_ADDR_CTRL, ctrl | 32'h0000_0001);
      repeat (5) @(posedge clock);
      @(negedge clock);
      pin_check(timerOut, k[0] ^ k[1]);
      repeat (40) @(posedge clock);
      @(negedge clock);
      pin_check(timerOut, ~k[0] ^ k[1]);
      pin_check(timerIrq, 1'b1);
      rd(`PT_ADDR_CTRL, ctrl, ALL);
      rd(`PT_ADDR_STAT, 32'h0000_0001, 32'h0000_0001);
      wr(`PT_ADDR_STAT, 32'h0000_0003);
      rd(`PT_ADDR_STAT, 32'h0000_0000, 32'h0000_0003);
    end
    wr(`PT_ADDR_CMPA, 32'h0000_00c8);
    wr(`PT_ADDR_CTRL, 32'h0000_001d);
    repeat (10) @(posedge clock);
    @(negedge clock);
    pin_check(timerOut, 1'b0);
    wr(`PT_ADDR_CTRL, 32'h0000_001c);
    rd(`PT_ADDR_STAT, 32'h0000_0000, 32'h0000_0001);
    @(negedge clock);
    pin_check(timerOut, 1'b1);
    wr(`PT_ADDR_CMPA, 32'h0000_0014);
    wr(`PT_ADDR_CTRL, 32'h0000_003c);
    pins.pulse(1'b1, 4);
    repeat (40) @(posedge clock);
    rd(`PT_ADDR_STAT, 32'h0000_0001, 32'h0000_0001);
    // Falling trigger: a long high pin must not start the pulse early
    wr(`PT_ADDR_STAT, 32'h0000_0003);
    wr(`PT_ADDR_CTRL, 32'h0000_023c);
    pins.pulse(1'b1, 30);
    rd(`PT_ADDR_STAT, 32'h0000_0000, 32'h0000_0001);
    repeat (40) @(posedge clock);
    rd(`PT_ADDR_STAT, 32'h0000_0001, 32'h0000_0001);
    wr(`PT_ADDR_CMPP, 32'h0000_0000);
    // External pin is never the counting clock here
    for (int io = 0; io < 4; io++) begin
      for (int src = 0; src < 2; src++) begin
        ctrl = 32'h0000_0162 | (io << 3) | (src << 7);
        wr(`PT_ADDR_CTRL, 32'h0000_0000);
        wr(`PT_ADDR_STAT, 32'h0000_0003);
        wr(`PT_ADDR_CMPA, 32'h0000_0014);
        wr(`PT_ADDR_CTRL, ctrl | 32'h0000_0001);
        pins.pulse(src[0], 4);
        repeat (12) @(posedge clock);
        rd(`PT_ADDR_STAT, {31'h0, io != 3}, 32'h0000_0001);
        rd(`PT_ADDR_CMPA, 32'h0000_0014, io == 3 ? ALL : 32'hffff_fc00);
        @(negedge clock);
        pin_check(timerOut, 1'b0);
      end
    end
    for (int p = 0; p < 2; p++) begin
      wr(`PT_ADDR_CTRL, 32'h0000_0000);
      wr(`PT_ADDR_STAT, 32'h0000_0003);
      wr(`PT_ADDR_CMPP, p ? 32'h0000_0000 : 32'h0000_001e);
      wr(`PT_ADDR_CTRL, 32'h0000_0003);
      repeat (200) @(posedge clock);
      rd(`PT_ADDR_STAT, p ? 32'h0000_0000 : 32'h0000_0002, 32'h0000_0002);
    end
    final_report();
  end

  initial begin
    #40000;
    nFail++;
    final_report();
  end
endmodule // testbench

bind periodic_timer periodic_timer_assertions chk (.clock(clock), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .extClockPin(extClockPin),
  .captureInputPin(captureInputPin), .timerOut(timerOut), .timerIrq(timerIrq));
